/* verilog/vector_stack_unit.sv */
// exception entry: vector resolution, context stacking, stack pointer,
// watchdog service location and a small register port
// assumes a synchronous vector ROM reader on the memory port and
// sources that hold their request until acknowledged
// Summary of operation
// RULE_01: two-byte vectors FFCC..FFFF, priority rises upward
// RULE_02: timer one ovf FFF2, ch1 FFF4, ch0 FFF6
// RULE_03: converter FFDE, timebase FFDC one step below
// RULE_04: CAN wake FFDA, err FFD8, rx FFD6, tx FFD4
// RULE_05: trap FFFC, pin FFFA, synthesiser FFF8
// RULE_06: push five context bytes before handler
// RULE_07: upper index byte never stacked
// RULE_08: call pushes two-byte return address
// RULE_09: push decrements, pull increments stack pointer
// RULE_10: stack pointer is sixteen bits
// RULE_11: stack pointer resets to 00FF
// RULE_12: any write to FFFF clears watchdog counter
// RULE_13: read of FFFF gives reset vector low; a read during ST_FETCH is ignored and cpu_rdata_o keeps its old value
// RULE_14: highest pending first, high then low byte
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "vector_stack_map.svh"
module vector_stack_unit
	import vector_stack_pkg::*;
#(
	parameter int N_SRC = `NUM_SOURCES
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// sources, index 0 lowest (timer_module_two ch5) .. 23 highest (external pin)
	input wire logic [N_SRC-1:0] src_req_i,
	input wire logic swi_i,
	input wire logic call_i,
	input wire logic pull_i,
	input wire cpu_context_t ctx_i,
	input wire logic [15:0] ret_addr_i,
	output logic busy_o,
	output logic entry_valid_o,
	output logic [15:0] handler_addr_o,
	output logic [4:0] ack_idx_o,
	output logic ack_o,
	// memory side
	output mem_write_t mem_wr_o,
	output logic [15:0] vec_rd_addr_o,
	input wire logic [7:0] vec_rd_data_i,
	output logic [15:0] sp_o,
	// cpu bus window on FFFF
	input wire logic [15:0] cpu_addr_i,
	input wire logic cpu_we_i,
	input wire logic cpu_re_i,
	output logic [7:0] cpu_rdata_o,
	output logic wdog_clear_o,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o,
	output logic irq_o
);
	seq_state_t state_ff, nxt_state;
	logic [15:0] sp_ff; // [RULE_10]
	logic [2:0] cnt_ff;
	logic [39:0] frame_ff;
	logic [2:0] frame_len_ff;
	logic is_irq_ff;
	logic [4:0] idx_ff;
	logic [15:0] vec_ff;
	logic byte_sel_ff;
	logic [7:0] vec_hi_ff;
	logic [15:0] handler_ff;
	logic entry_ff;
	logic [7:0] status_ff;
	logic [7:0] mask_ff;
	logic rd_pend_ff;
	logic [7:0] cpu_rdata_ff;
	logic [7:0] reg_rdata_ff;
	logic any_req;
	logic [4:0] pick_idx;
	logic start;
	logic [2:0] ev;
	logic is_trap_ff;
	logic wd_rd, wd_rd_ff;

	// table is linear, so index order and address order rank alike
	function automatic logic [15:0] vec_of(input logic [4:0] idx);
		return `VEC_TABLE_BASE + {10'h000, idx, 1'b0}; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
	endfunction

	priority_picker #(
		.N(N_SRC)
	) u_pick (
		.req_i(src_req_i),
		.any_o(any_req),
		.idx_o(pick_idx)
	);

	assign start = (state_ff == ST_IDLE) && !entry_ff && (swi_i || any_req || call_i);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (start)
				begin
					nxt_state = ST_PUSH;
				end
			end
			ST_PUSH:
			begin
				if (cnt_ff == frame_len_ff - 3'h1)
				begin
					nxt_state = is_irq_ff ? ST_FETCH : ST_DONE;
				end
			end
			ST_FETCH:
			begin
				if (byte_sel_ff && rd_pend_ff)
				begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE:
			begin
				nxt_state = ST_IDLE;
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_ff <= ST_IDLE;
			entry_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			entry_ff <= (state_ff == ST_DONE) && is_irq_ff;
		end
	end

	// capture the frame; trap beats sources, sources beat a call
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			frame_ff <= 40'h0;
			frame_len_ff <= 3'h0;
			is_irq_ff <= 1'b0;
			idx_ff <= 5'h00;
			vec_ff <= 16'h0000;
			cnt_ff <= 3'h0;
			is_trap_ff <= 1'b0;
		end
		else if (start)
		begin
			cnt_ff <= 3'h0;
			is_trap_ff <= swi_i;
			if (swi_i || any_req)
			begin
				// pc lo, pc hi, idx lo, acc, ccr; upper index omitted
				frame_ff <= {ctx_i.ccr, ctx_i.acc, ctx_i.idx_lo, ctx_i.pc}; // [RULE_06] [RULE_07]
				frame_len_ff <= `IRQ_FRAME_BYTES; // [RULE_06]
				is_irq_ff <= 1'b1;
				idx_ff <= pick_idx;
				vec_ff <= swi_i ? `VEC_SWI_HI : vec_of(pick_idx); // [RULE_05] [RULE_14]
			end
			else
			begin
				frame_ff <= {24'h000000, ret_addr_i}; // [RULE_08]
				frame_len_ff <= `CALL_FRAME_BYTES; // [RULE_08]
				is_irq_ff <= 1'b0;
			end
		end
		else if (state_ff == ST_PUSH)
		begin
			cnt_ff <= cnt_ff + 3'h1;
			frame_ff <= {8'h00, frame_ff[39:8]};
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sp_ff <= `SP_RESET; // [RULE_11]
		end
		else if (state_ff == ST_PUSH)
		begin
			sp_ff <= sp_ff - 16'h0001; // [RULE_09]
		end
		else if (state_ff == ST_IDLE && !start && pull_i)
		begin
			sp_ff <= sp_ff + 16'h0001; // [RULE_09]
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mem_wr_o <= '0;
		end
		else
		begin
			mem_wr_o.we <= (state_ff == ST_PUSH);
			mem_wr_o.addr <= sp_ff;
			mem_wr_o.data <= frame_ff[7:0];
		end
	end

	// vector fetch: high byte first, then low
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			byte_sel_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			vec_hi_ff <= 8'h00;
			handler_ff <= 16'h0000;
		end
		else if (state_ff == ST_FETCH)
		begin
			rd_pend_ff <= ~rd_pend_ff;
			if (rd_pend_ff)
			begin
				if (!byte_sel_ff)
				begin
					vec_hi_ff <= vec_rd_data_i;
					byte_sel_ff <= 1'b1;
				end
				else
				begin
					handler_ff <= {vec_hi_ff, vec_rd_data_i}; // [RULE_14]
					byte_sel_ff <= 1'b0;
				end
			end
		end
		else
		begin
			byte_sel_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
		end
	end

	// a read of the service location borrows the rom port, but never mid-fetch
	assign vec_rd_addr_o = wd_rd ? `WDOG_SERVICE_ADDR : vec_ff | {15'h0000, byte_sel_ff}; // [RULE_13]

	assign entry_valid_o = entry_ff;
	assign handler_addr_o = handler_ff;
	assign ack_o = entry_ff && !is_trap_ff;
	assign ack_idx_o = idx_ff;
	assign busy_o = (state_ff != ST_IDLE);
	assign sp_o = sp_ff;

	// watchdog service: write clears, read outside ST_FETCH returns reset vector low
	assign wdog_clear_o = cpu_we_i && (cpu_addr_i == `WDOG_SERVICE_ADDR); // [RULE_12]
	assign wd_rd = cpu_re_i && (cpu_addr_i == `WDOG_SERVICE_ADDR) && (state_ff != ST_FETCH);

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cpu_rdata_ff <= 8'h00;
			wd_rd_ff <= 1'b0;
		end
		else
		begin
			wd_rd_ff <= wd_rd;
			if (wd_rd_ff)
			begin
				cpu_rdata_ff <= vec_rd_data_i; // [RULE_13]
			end
		end
	end
	assign cpu_rdata_o = cpu_rdata_ff;

	// events: entry taken, call stacked, watchdog serviced
	assign ev = {wdog_clear_o, (state_ff == ST_DONE) && !is_irq_ff, entry_ff};

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			status_ff <= 8'h00;
			mask_ff <= 8'h00;
		end
		else
		begin
			if (reg_we_i && reg_addr_i == `REG_MASK)
			begin
				mask_ff <= reg_wdata_i;
			end
			if (reg_we_i && reg_addr_i == `REG_STATUS)
			begin
				status_ff <= (status_ff & ~reg_wdata_i) | {5'h00, ev};
			end
			else
			begin
				status_ff <= status_ff | {5'h00, ev};
			end
		end
	end

	assign irq_o = |(status_ff & mask_ff);

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			reg_rdata_ff <= 8'h00;
		end
		else if (reg_re_i)
		begin
			case (reg_addr_i)
				`REG_STATUS: reg_rdata_ff <= status_ff;
				`REG_MASK: reg_rdata_ff <= mask_ff;
				`REG_SP_HI: reg_rdata_ff <= sp_ff[15:8];
				`REG_SP_LO: reg_rdata_ff <= sp_ff[7:0];
				`REG_VEC_HI: reg_rdata_ff <= handler_ff[15:8];
				`REG_VEC_LO: reg_rdata_ff <= handler_ff[7:0];
				default: reg_rdata_ff <= 8'h00;
			endcase
		end
	end
	assign reg_rdata_o = reg_rdata_ff;
endmodule
`default_nettype wire

/* verilog/vector_stack_map.svh */
// address map, vector table and reset values for the vector and stack unit
// assumes a 16-bit address space and an 8-bit data path
`ifndef VECTOR_STACK_MAP_SVH
`define VECTOR_STACK_MAP_SVH
`define VEC_TABLE_BASE 16'hffcc
`define VEC_TABLE_TOP 16'hffff
`define VEC_RESET_HI 16'hfffe
`define VEC_SWI_HI 16'hfffc
`define VEC_EXT_PIN_HI 16'hfffa
`define VEC_SYNTH_HI 16'hfff8
`define VEC_T1_CH0_HI 16'hfff6
`define VEC_T1_CH1_HI 16'hfff4
`define VEC_T1_OVF_HI 16'hfff2
`define VEC_ADC_HI 16'hffde
`define VEC_TBASE_HI 16'hffdc
`define VEC_CAN_WAKE_HI 16'hffda
`define VEC_CAN_ERR_HI 16'hffd8
`define VEC_CAN_RX_HI 16'hffd6
`define VEC_CAN_TX_HI 16'hffd4
`define WDOG_SERVICE_ADDR 16'hffff
`define SP_RESET 16'h00ff
`define IRQ_FRAME_BYTES 3'h5
`define CALL_FRAME_BYTES 3'h2
// software registers of the unit itself
`define REG_STATUS 8'h00
`define REG_MASK 8'h01
`define REG_SP_HI 8'h02
`define REG_SP_LO 8'h03
`define REG_VEC_HI 8'h04
`define REG_VEC_LO 8'h05
`define NUM_SOURCES 24
`endif

/* verilog/vector_stack_pkg.sv */
// types shared by the vector and stack unit
// assumes vector_stack_map.svh is available on the include path
package vector_stack_pkg;
	typedef struct packed {
		logic [7:0] ccr;
		logic [7:0] acc;
		logic [7:0] idx_lo;
		logic [15:0] pc;
	} cpu_context_t;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
	} mem_write_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PUSH = 4'b0010,
		ST_FETCH = 4'b0100,
		ST_DONE = 4'b1000
	} seq_state_t;
endpackage

/* verilog/priority_picker.sv */
// fixed-priority pick over the pending sources; higher index wins
// assumes sources are ordered so index 0 is the lowest priority
`timescale 1ns/1ps
`default_nettype none
module priority_picker #(
	parameter int N = 24
) (
	input wire logic [N-1:0] req_i,
	output logic any_o,
	output logic [4:0] idx_o
);
	always_comb
	begin
		idx_o = 5'h00;
		any_o = |req_i;
		for (int i = 0; i < N; i++)
		begin
			if (req_i[i])
			begin
				idx_o = 5'(i);
			end
		end
	end
endmodule
`default_nettype wire

/* test/vector_rom_model.sv */
// synchronous vector rom model on the unit's fetch port
// assumes one byte is read per cycle, data one cycle late
`timescale 1ns/1ps
`default_nettype none
module vector_rom_model
(
	input wire logic clk_sys_i,
	input wire logic [15:0] addr_i,
	output logic [7:0] data_o
);
	// scrambled so high and low bytes never match by chance
	always_ff @(posedge clk_sys_i)
		data_o <= addr_i[7:0] ^ 8'ha5;
endmodule
`default_nettype wire

/* test/vector_stack_unit_checker.sv */
// assertions on the vector and stack unit ports
// assumes it is bound into every unit instance
`timescale 1ns/1ps
`default_nettype none
module vector_stack_unit_checker
	import vector_stack_pkg::*;
#(
	parameter int N_SRC = 24
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [N_SRC-1:0] src_req_i,
	input wire logic swi_i,
	input wire logic call_i,
	input wire logic pull_i,
	input wire logic busy_o,
	input wire logic entry_valid_o,
	input wire logic ack_o,
	input wire mem_write_t mem_wr_o,
	input wire logic [15:0] sp_o,
	input wire logic [15:0] cpu_addr_i,
	input wire logic cpu_we_i,
	input wire logic wdog_clear_o
);
	// length of the current run of stack writes
	logic [2:0] run_ff;
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
			run_ff <= 3'h0;
		else if (mem_wr_o.we)
			run_ff <= run_ff + 3'h1;
		else
			run_ff <= 3'h0;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence s_idle_pull;
		pull_i && !busy_o && !swi_i && !call_i && !(|src_req_i);
	endsequence
	sequence s_push_pair;
		mem_wr_o.we && $past(mem_wr_o.we);
	endsequence
	a_sp_reset: assert property ($rose(nrst_i) |-> sp_o == 16'h00ff)
		else $error("sp not at reset value");
	a_wdog_clear: assert property (wdog_clear_o == (cpu_we_i && cpu_addr_i == 16'hffff))
		else $error("watchdog clear mismatch");
	a_push_step: assert property (s_push_pair |-> mem_wr_o.addr == $past(mem_wr_o.addr) - 16'h1)
		else $error("push address not descending");
	a_frame_len: assert property ($fell(mem_wr_o.we) |-> run_ff == 3'h5 || run_ff == 3'h2)
		else $error("frame length wrong");
	a_write_busy: assert property (mem_wr_o.we |-> busy_o)
		else $error("write while idle");
	a_ack_entry: assert property (ack_o |-> entry_valid_o)
		else $error("ack without entry");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than a cycle");
	a_pull_inc: assert property (s_idle_pull |=> sp_o == $past(sp_o) + 16'h1)
		else $error("pull did not raise sp");
endmodule
bind vector_stack_unit vector_stack_unit_checker #(.N_SRC(N_SRC)) chk_i (.clk_sys_i, .nrst_i,
	.src_req_i, .swi_i, .call_i, .pull_i, .busy_o, .entry_valid_o, .ack_o, .mem_wr_o, .sp_o,
	.cpu_addr_i, .cpu_we_i, .wdog_clear_o);
`default_nettype wire

/* test/tb_vector_stack_unit.sv */
// testbench: vectors, stacking, stack pointer, watchdog window, registers
// assumes the rom model serves vector bytes one cycle late
`timescale 1ns/1ps
`default_nettype none
module tb_vector_stack_unit import vector_stack_pkg::*;;
	logic clk_sys_i, nrst_i, swi_i, call_i, pull_i, busy_o, entry_valid_o, ack_o;
	logic cpu_we_i, cpu_re_i, wdog_clear_o, reg_we_i, reg_re_i, irq_o;
	logic [23:0] src_req_i;
	logic [15:0] ret_addr_i, handler_addr_o, vec_rd_addr_o, sp_o, cpu_addr_i;
	logic [7:0] vec_rd_data_i, cpu_rdata_o, reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [4:0] ack_idx_o;
	cpu_context_t ctx_i;
	mem_write_t mem_wr_o;
	int fails, check_count;
	vector_stack_unit DUT (.*);
	vector_rom_model rom (.clk_sys_i(clk_sys_i), .addr_i(vec_rd_addr_o), .data_o(vec_rd_data_i));
	initial
	begin
		clk_sys_i = 0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic results();
		$display("fails %0d checks %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1;
		@(posedge clk_sys_i);
		reg_we_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_re_i <= 1;
		@(posedge clk_sys_i);
		reg_re_i <= 0;
		@(negedge clk_sys_i);
		chk(reg_rdata_o, exp);
	endtask
	// one entry: request, watch the stack writes, then the handler
	task automatic go(input logic [23:0] rq, input logic sw, input logic cl, input logic [15:0] h);
		int i;
		int k;
		logic [39:0] b;
		logic [15:0] sp0;
		logic done;
		logic clr;
		b = cl ? 40'hbeef : 40'hc1a2531234;
		k = 0;
		done = 0;
		@(negedge clk_sys_i);
		sp0 = sp_o;
		@(posedge clk_sys_i);
		src_req_i <= rq;
		swi_i <= sw;
		call_i <= cl;
		ctx_i <= b;
		ret_addr_i <= b[15:0];
		for (i = 0; i < 40 && !done; i++)
		begin
			@(negedge clk_sys_i);
			if (mem_wr_o.we)
			begin
				chk(mem_wr_o.addr, sp0 - 16'(k));
				chk(mem_wr_o.data, b[8*k+:8]);
				k++;
			end
			// sources hold until ack, the trap only until taken
			clr = ack_o || (swi_i && busy_o);
			if (entry_valid_o)
			begin
				chk(handler_addr_o, {h[7:0] ^ 8'ha5, (h[7:0] + 8'h1) ^ 8'ha5});
				chk(ack_o, {15'h0000, !sw});
				if (!sw)
				begin
					chk(ack_idx_o, (h - 16'hffcc) >> 1);
				end
				done = 1;
			end
			if (cl && k == 2 && !busy_o)
				done = 1;
			@(posedge clk_sys_i);
			call_i <= 0;
			if (clr)
			begin
				src_req_i <= '0;
				swi_i <= 0;
			end
		end
		if (!done)
		begin
			fails++;
			$display("BAD %0t no completion", $time);
			results();
		end
		@(negedge clk_sys_i);
		chk(16'(k), cl ? 16'h2 : 16'h5);
		chk(sp_o, sp0 - (cl ? 16'h2 : 16'h5));
	endtask
	task automatic t_reset();
		chk(sp_o, 16'h00ff);
		rd(8'h02, 8'h00);
		rd(8'h03, 8'hff);
	endtask
	task automatic t_wdog();
		@(posedge clk_sys_i);
		cpu_we_i <= 1;
		@(negedge clk_sys_i);
		chk(wdog_clear_o, 16'h1);
		@(posedge clk_sys_i);
		cpu_addr_i <= 16'hfffe;
		@(negedge clk_sys_i);
		chk(wdog_clear_o, 16'h0);
		@(posedge clk_sys_i);
		cpu_addr_i <= 16'hffff;
		cpu_we_i <= 0;
		cpu_re_i <= 1;
		@(negedge clk_sys_i);
		chk(wdog_clear_o, 16'h0);
		@(posedge clk_sys_i);
		cpu_re_i <= 0;
		repeat (3) @(negedge clk_sys_i);
		chk(cpu_rdata_o, 16'h5a);
	endtask
	task automatic t_pull();
		logic [15:0] sp0;
		@(negedge clk_sys_i);
		sp0 = sp_o;
		@(posedge clk_sys_i);
		pull_i <= 1;
		@(posedge clk_sys_i);
		pull_i <= 0;
		@(negedge clk_sys_i);
		chk(sp_o, sp0 + 16'h1);
	endtask
	task automatic t_vectors();
		go(24'h000001, 0, 0, 16'hffcc);
		go(24'h0000f0, 0, 0, 16'hffda);
		go(24'h000070, 0, 0, 16'hffd8);
		go(24'h000030, 0, 0, 16'hffd6);
		go(24'h000010, 0, 0, 16'hffd4);
		go(24'h000300, 0, 0, 16'hffde);
		go(24'h000100, 0, 0, 16'hffdc);
		go(24'h380000, 0, 0, 16'hfff6);
		go(24'h180000, 0, 0, 16'hfff4);
		go(24'h080000, 0, 0, 16'hfff2);
		go(24'hc00000, 0, 0, 16'hfffa);
		go(24'h400000, 0, 0, 16'hfff8);
		go(24'h000000, 1, 0, 16'hfffc);
	endtask
	task automatic t_regs();
		rd(8'h00, 8'h07);
		chk(irq_o, 16'h0);
		wr(8'h01, 8'h01);
		@(negedge clk_sys_i);
		chk(irq_o, 16'h1);
		wr(8'h00, 8'h01);
		@(negedge clk_sys_i);
		chk(irq_o, 16'h0);
		rd(8'h00, 8'h06);
		rd(8'h3f, 8'h00);
	endtask
	initial
	begin
		nrst_i = 0;
		src_req_i = '0;
		swi_i = 0;
		call_i = 0;
		pull_i = 0;
		ctx_i = '0;
		ret_addr_i = 16'h0;
		cpu_addr_i = 16'hffff;
		cpu_we_i = 0;
		cpu_re_i = 0;
		reg_addr_i = 8'h0;
		reg_wdata_i = 8'h0;
		reg_we_i = 0;
		reg_re_i = 0;
		fails = 0;
		check_count = 0;
		repeat (6) @(posedge clk_sys_i);
		nrst_i <= 1;
		t_reset();
		t_wdog();
		go(24'h0, 0, 1, 16'h0);
		t_pull();
		t_vectors();
		t_regs();
		results();
	end
endmodule
`default_nettype wire
